// >>> dv/rfe_host_model.sv
// Bus master model for the two-wire management link: start, stop and byte transfers.
// Assumes the bench builds the open-drain wire, with pull-up, from both enables.
`timescale 1ns/1ns
`default_nettype none
module rfe_host_model (
  input wire logic clock,
  input wire logic sda,
  output logic scl,
  output logic sda_m
);
  //////////////////////////////////////////////////////////////////////////////
  // Clock rests high between frames; it never runs free
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end

  // Quarter of the 160 ns serial period
  task automatic qtr();
    repeat (10) @(posedge clock);
  endtask : qtr

  task automatic start_c();
    sda_m <= 1'b1;
    qtr();
    scl <= 1'b1;
    qtr();
    sda_m <= 1'b0;
    qtr();
    scl <= 1'b0;
    qtr();
  endtask : start_c

  task automatic stop_c();
    sda_m <= 1'b0;
    qtr();
    scl <= 1'b1;
    qtr();
    sda_m <= 1'b1;
    qtr();
  endtask : stop_c

  //////////////////////////////////////////////////////////////////////////////
  // Data moves a quarter period after the fall, so hold is never marginal
  task automatic xbit(input logic b, output logic s);
    sda_m <= b;
    qtr();
    scl <= 1'b1;
    qtr();
    s = sda;
    qtr();
    scl <= 1'b0;
    qtr();
  endtask : xbit

  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      xbit(b[i], s);
    end
    xbit(1'b1, s);
    ack = ~s;
  endtask : wbyte

  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      xbit(1'b1, d[i]);
    end
    xbit(nack, s);
  endtask : rbyte
endmodule : rfe_host_model
`default_nettype wire

// >>> dv/rfe_top_test.sv
// Self-checking bench for the read framing and fault handling of the link slave.
// Assumes rfe_top and rfe_host_model; the wire is pulled up unless someone pulls low.
`timescale 1ns/1ns
`default_nettype none
`include "rfe_params.svh"
module rfe_top_test;
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] exp;
  } rfe_row_type;

  logic clock;
  logic rstn;
  logic scl;
  logic sda_m;
  logic sda_out;
  logic sda_oe_n;
  logic cmd_error;
  wire sda;
  int n_errors = 0;
  int tests_run = 0;
  rfe_row_type rows [4] = '{'{`RFE_OFS_CMD_STATE, 16'hC000}, '{`RFE_OFS_FAULT_CAUSE, 16'h0400},
    '{`RFE_OFS_FAULT_LOC, 16'h0000}, '{16'hB051, 16'h0000}};

  assign sda = sda_m & sda_oe_n;

  rfe_top #(.SYNC_STAGES(2)) i_dut (.clock(clock), .rstn(rstn), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .cmd_error(cmd_error));
  rfe_host_model i_host (.clock(clock), .sda(sda), .scl(scl), .sda_m(sda_m));

  //////////////////////////////////////////////////////////////////////////////
  initial clock = 1'b0;
  always #2 clock = ~clock;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  // na address bytes before a repeated start (0 = current address), nb bytes read
  task automatic rd_frame(input logic [15:0] addr, input int na, input int nb,
                          output logic ack, output logic [31:0] w);
    logic a;
    logic [7:0] b;
    w = 32'h0;
    i_host.start_c();
    if (na > 0) begin
      i_host.wbyte({`RFE_SLAVE_ADDR, 1'b0}, a);
      i_host.wbyte(addr[15:8], a);
      if (na > 1) begin
        i_host.wbyte(addr[7:0], a);
      end
      i_host.start_c();
    end
    i_host.wbyte({`RFE_SLAVE_ADDR, 1'b1}, ack);
    if (ack) begin
      for (int k = 0; k < nb; k++) begin
        i_host.rbyte(k == nb - 1, b);
        w = {w[23:0], b};
      end
    end
    i_host.stop_c();
  endtask : rd_frame

  task automatic wr_word(input logic [15:0] addr, input logic [15:0] data);
    logic a;
    i_host.start_c();
    i_host.wbyte({`RFE_SLAVE_ADDR, 1'b0}, a);
    check(a, 1'b1);
    i_host.wbyte(addr[15:8], a);
    i_host.wbyte(addr[7:0], a);
    i_host.wbyte(data[15:8], a);
    i_host.wbyte(data[7:0], a);
    i_host.stop_c();
  endtask : wr_word

  // Clearing both flags; the location register needs no clearing
  task automatic clear_faults();
    logic a;
    logic [31:0] w;
    wr_word(`RFE_OFS_CMD_STATE, 16'h4000);
    wr_word(`RFE_OFS_FAULT_CAUSE, 16'h0400);
    check(cmd_error, 1'b0);
    rd_frame(`RFE_OFS_FAULT_CAUSE, 2, 2, a, w);
    check(w[15:0], 16'h0000);
  endtask : clear_faults

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (90000) @(posedge clock);
    $display("timeout at %0t", $time);
    n_errors++;
    test_done();
  end

  initial begin
    logic a;
    logic [31:0] w;
    rstn = 1'b0;
    repeat (3) @(posedge clock);
    check(sda_oe_n, 1'b1);
    check(cmd_error, 1'b0);
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    repeat (10) @(posedge clock);
    $display("test reset done");
    // Pointer starts invalid, so the very first current read is refused
    rd_frame(16'h0, 0, 2, a, w);
    check(a, 1'b0);
    check(cmd_error, 1'b1);
    check(sda_out, 1'b0);
    $display("test invalid pointer done");
    foreach (rows[i]) begin
      rd_frame(rows[i].addr, 2, 2, a, w);
      check(a, 1'b1);
      check(w[15:0], rows[i].exp);
    end
    $display("test table done");
    clear_faults();
    // Foreign slave address: refused, and no error raised
    i_host.start_c();
    i_host.wbyte({7'h51, 1'b1}, a);
    i_host.stop_c();
    check(a, 1'b0);
    check(cmd_error, 1'b0);
    $display("test foreign address done");
    rd_frame(16'hB04F, 2, 4, a, w);
    check(w, 32'h0000_8000);
    rd_frame(16'h0, 0, 2, a, w);
    check(a, 1'b1);
    check(w[15:0], 16'h0000);
    $display("test sequential done");
    // Only the upper address byte before the repeated start
    rd_frame(`RFE_OFS_CMD_STATE, 1, 1, a, w);
    check(a, 1'b1);
    check(w[7:0], 8'hFF);
    check(cmd_error, 1'b1);
    rd_frame(16'h0, 0, 2, a, w);
    check(a, 1'b0);
    $display("test partial address done");
    clear_faults();
    // Master gives up after the upper byte
    rd_frame(`RFE_OFS_CMD_STATE, 2, 1, a, w);
    check(w[7:0], 8'h80);
    check(cmd_error, 1'b1);
    rd_frame(16'h0, 0, 2, a, w);
    check(a, 1'b0);
    rd_frame(`RFE_OFS_FAULT_LOC, 2, 2, a, w);
    check(w[15:0], `RFE_FAULT_LOC_ON_ERR);
    rd_frame(`RFE_OFS_FAULT_CAUSE, 2, 2, a, w);
    check(w[15:0], 16'h0400);
    $display("test early nack done");
    test_done();
  end
endmodule : rfe_top_test
`default_nettype wire

// >>> verilog/rfe_byte_if.sv
// Byte-level handshake between the link engine and the frame controller.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
`default_nettype none
interface rfe_byte_if;
  logic start;
  logic stop;
  logic rx_done;
  logic [7:0] rx_byte;
  logic tx_done;
  logic m_nack;
  logic ack_give;
  logic tx_mode;
  logic [7:0] tx_byte;
  modport phy (output start, stop, rx_done, rx_byte, tx_done, m_nack,
               input ack_give, tx_mode, tx_byte);
  modport ctl (input start, stop, rx_done, rx_byte, tx_done, m_nack,
               output ack_give, tx_mode, tx_byte);
endinterface : rfe_byte_if
`default_nettype wire

// >>> verilog/rfe_link_phy.sv
// Bit engine of the two-wire slave: pin sampling, start/stop, byte shifting.
// Assumes the serial clock is far slower than the system clock.
`timescale 1ns/1ns
`default_nettype none
`include "rfe_params.svh"
module rfe_link_phy #(
  parameter int SYNC_STAGES = 2
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  rfe_byte_if.phy lnk
);
  import rfe_pkg::*;

  generate
    if (SYNC_STAGES < 2) begin : g_bad_sync
      $error("SYNC_STAGES must be at least 2");
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  logic [SYNC_STAGES-1:0] scl_sq;
  logic [SYNC_STAGES-1:0] sda_sq;
  logic scl_prev_q;
  logic sda_prev_q;
  rfe_phase_type phase_q;
  logic [2:0] cnt_q;
  logic [7:0] shift_q;
  logic armed_q;

  wire scl_s = scl_sq[SYNC_STAGES-1];
  wire sda_s = sda_sq[SYNC_STAGES-1];
  wire scl_rise = scl_s & ~scl_prev_q;
  wire scl_fall = ~scl_s & scl_prev_q;
  // Line changes while the clock stays high mark frame boundaries
  wire start_c = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  wire stop_c = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
  wire last_bit = (cnt_q == `RFE_LAST_BIT);
  wire drive_d = ((phase_q == PH_RACK) & lnk.ack_give) | ((phase_q == PH_TX) & ~shift_q[7]);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      scl_sq <= '1;
      sda_sq <= '1;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_sq <= {scl_sq[SYNC_STAGES-2:0], scl_in};
      sda_sq <= {sda_sq[SYNC_STAGES-2:0], sda_in};
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      phase_q <= PH_IDLE;
      cnt_q <= 3'h0;
      shift_q <= 8'h00;
      lnk.m_nack <= 1'b0;
      armed_q <= 1'b0;
    end else if (start_c) begin
      // The clock fall that closes a start carries no data bit
      phase_q <= PH_RX;
      cnt_q <= 3'h0;
      armed_q <= 1'b0;
    end else if (stop_c) begin
      phase_q <= PH_IDLE;
    end else begin
      case (phase_q)
        PH_RX: begin
          if (scl_rise) begin
            shift_q <= {shift_q[6:0], sda_s};
            armed_q <= 1'b1;
          end
          if (scl_fall & armed_q) begin
            cnt_q <= cnt_q + 3'h1;
            if (last_bit) begin
              phase_q <= PH_RACK;
            end
          end
        end
        PH_RACK: begin
          if (scl_fall) begin
            cnt_q <= 3'h0;
            shift_q <= lnk.tx_byte;
            if (!lnk.ack_give) begin
              phase_q <= PH_IDLE;
            end else if (lnk.tx_mode) begin
              phase_q <= PH_TX;
            end else begin
              phase_q <= PH_RX;
            end
          end
        end
        PH_TX: begin
          if (scl_fall) begin
            cnt_q <= cnt_q + 3'h1;
            shift_q <= {shift_q[6:0], 1'b1};
            if (last_bit) begin
              phase_q <= PH_TACK;
            end
          end
        end
        PH_TACK: begin
          if (scl_rise) begin
            lnk.m_nack <= sda_s;
          end
          if (scl_fall) begin
            // A master NACK ends the data phase; the line stays released
            phase_q <= (lnk.m_nack | ~lnk.tx_mode) ? PH_IDLE : PH_TX;
            shift_q <= lnk.tx_byte;
            cnt_q <= 3'h0;
          end
        end
        default: begin
          phase_q <= PH_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      lnk.start <= 1'b0;
      lnk.stop <= 1'b0;
      lnk.rx_done <= 1'b0;
      lnk.rx_byte <= 8'h00;
      lnk.tx_done <= 1'b0;
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
    end else begin
      lnk.start <= start_c;
      lnk.stop <= stop_c;
      lnk.rx_done <= (phase_q == PH_RX) & scl_fall & armed_q & last_bit & ~start_c & ~stop_c;
      lnk.rx_byte <= shift_q;
      lnk.tx_done <= (phase_q == PH_TACK) & scl_rise & ~start_c & ~stop_c;
      sda_out <= 1'b0;
      sda_oe_n <= ~drive_d;
    end
  end
endmodule : rfe_link_phy
`default_nettype wire

// >>> verilog/rfe_params.svh
// Constants for the two-wire read framing and error handler.
// Assumes inclusion by bare name from the design modules and the testbench.
// What this block does
// RULE1 - Invalid current address: NACK the read
// RULE2 - Partial word address: ACK the read, return idle 0xFF bytes
// RULE3 - Partial word address: mark current address invalid
// RULE4 - Early NACK or STOP: mark address invalid
// RULE5 - Any read error sets command error flag
// RULE6 - Any read error sets link protocol fault
// RULE7 - Any read error loads fault location zero
// RULE8 - Master acks bytes; address advances per word
// RULE9 - Answer fixed seven-bit address, eighth bit direction
// RULE10 - Addresses and data are two bytes, upper first
// RULE11 - Errors update the whole fault register group
`ifndef RFE_PARAMS_SVH
`define RFE_PARAMS_SVH
`define RFE_SLAVE_ADDR 7'h50
`define RFE_OFS_FAULT_LOC 16'hB00C
`define RFE_OFS_FAULT_CAUSE 16'hB00F
`define RFE_OFS_CMD_STATE 16'hB050
`define RFE_BIT_CMD_READY 15
`define RFE_BIT_CMD_ERR 14
`define RFE_BIT_LINK_FAULT 10
`define RFE_FAULT_LOC_ON_ERR 16'h0000
`define RFE_RST_WORD 16'h0000
`define RFE_IDLE_BYTE 8'hFF
`define RFE_LAST_BIT 3'h7
`endif

// >>> verilog/rfe_pkg.sv
// Types shared by the link engine and the frame controller.
// Assumes nothing beyond a SystemVerilog compiler.
package rfe_pkg;
  typedef enum logic [2:0] {PH_IDLE, PH_RX, PH_RACK, PH_TX, PH_TACK} rfe_phase_type;
  typedef enum logic [2:0] {ST_IDLE, ST_CTRL, ST_AHI, ST_ALO, ST_WHI, ST_WLO, ST_RD, ST_DONE}
    rfe_state_type;
endpackage : rfe_pkg

// >>> verilog/rfe_top.sv
// Two-wire management slave: read framing, error detection and fault registers.
// Assumes an external pull-up on both lines and a host acting as bus master.
`timescale 1ns/1ns
`default_nettype none
`include "rfe_params.svh"
module rfe_top #(
  parameter int SYNC_STAGES = 2
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic cmd_error
);
  import rfe_pkg::*;

  rfe_byte_if lnk ();

  rfe_link_phy #(.SYNC_STAGES(SYNC_STAGES)) u_phy (
    .clock(clock),
    .rstn(rstn),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n),
    .lnk(lnk.phy)
  );

  //////////////////////////////////////////////////////////////////////////////
  rfe_state_type state_q;
  rfe_state_type state_d;
  logic [15:0] cur_addr_q;
  logic addr_valid_q;
  logic partial_q;
  logic lo_sel_q;
  logic [7:0] hi_q;
  logic [7:0] lo_q;
  logic cmd_err_q;
  logic link_fault_q;
  logic [15:0] fault_loc_q;
  logic ack_q;
  logic tx_mode_q;
  logic [7:0] tx_byte_q;

  assign lnk.ack_give = ack_q;
  assign lnk.tx_mode = tx_mode_q;
  assign lnk.tx_byte = tx_byte_q;
  assign cmd_error = cmd_err_q;

  wire in_rd = (state_q == ST_RD);
  wire in_ctrl = lnk.rx_done & (state_q == ST_CTRL);
  wire ctrl_match = (lnk.rx_byte[7:1] == `RFE_SLAVE_ADDR); // RULE9
  wire ctrl_read = lnk.rx_byte[0];
  wire rd_req = in_ctrl & ctrl_match & ctrl_read;
  wire err_invalid = rd_req & ~partial_q & ~addr_valid_q; // RULE1
  wire err_partial = rd_req & partial_q; // RULE2
  wire rd_ok = rd_req & ~partial_q & addr_valid_q;
  wire hi_done = lnk.tx_done & in_rd & ~lo_sel_q;
  wire lo_done = lnk.tx_done & in_rd & lo_sel_q;
  // Boundary inside a read frame means the word was not finished
  wire err_early = (in_rd & (lnk.start | lnk.stop)) | (hi_done & lnk.m_nack); // RULE4
  wire err_any = err_invalid | err_partial | err_early;
  wire wr_word = lnk.rx_done & (state_q == ST_WLO);
  wire [15:0] wr_data = {hi_q, lnk.rx_byte}; // RULE10
  wire [15:0] next_addr = cur_addr_q + 16'h0001;
  wire [15:0] sel_addr = in_rd ? next_addr : cur_addr_q;
  wire [15:0] cause_word = 16'(link_fault_q) << `RFE_BIT_LINK_FAULT;
  wire [15:0] state_word = (16'h0001 << `RFE_BIT_CMD_READY) | (16'(cmd_err_q) << `RFE_BIT_CMD_ERR);
  wire [15:0] rd_word = (sel_addr == `RFE_OFS_FAULT_LOC) ? fault_loc_q :
                        (sel_addr == `RFE_OFS_FAULT_CAUSE) ? cause_word :
                        (sel_addr == `RFE_OFS_CMD_STATE) ? state_word : `RFE_RST_WORD;
  wire clr_err = wr_word & (cur_addr_q == `RFE_OFS_CMD_STATE) & wr_data[`RFE_BIT_CMD_ERR];
  wire clr_fault = wr_word & (cur_addr_q == `RFE_OFS_FAULT_CAUSE) & wr_data[`RFE_BIT_LINK_FAULT];
  wire ack_d = in_ctrl ? (ctrl_match & (~ctrl_read | partial_q | addr_valid_q)) :
               (state_q == ST_AHI) | (state_q == ST_ALO) | (state_q == ST_WHI) |
               (state_q == ST_WLO);

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_d = state_q;
    if (lnk.start) begin
      state_d = ST_CTRL;
    end else if (lnk.stop) begin
      state_d = ST_IDLE;
    end else if (lnk.rx_done) begin
      case (state_q)
        ST_CTRL: state_d = !ctrl_match ? ST_IDLE : !ctrl_read ? ST_AHI :
                           partial_q ? ST_DONE : addr_valid_q ? ST_RD : ST_IDLE;
        ST_AHI: state_d = ST_ALO;
        ST_ALO: state_d = ST_WHI;
        ST_WHI: state_d = ST_WLO;
        ST_WLO: state_d = ST_WHI;
        default: state_d = state_q;
      endcase
    end else if (lnk.tx_done & in_rd & lnk.m_nack) begin
      state_d = ST_DONE; // RULE8
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      ack_q <= 1'b0;
      lo_sel_q <= 1'b0;
      partial_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (lnk.rx_done) begin
        ack_q <= ack_d;
      end
      lo_sel_q <= (lnk.start | lnk.stop | rd_ok) ? 1'b0 : lnk.tx_done ? ~lo_sel_q : lo_sel_q;
      // Only one address byte seen before the repeated start
      if (lnk.start) begin
        partial_q <= (state_q == ST_ALO);
      end else if (in_ctrl) begin
        partial_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cur_addr_q <= `RFE_RST_WORD;
      addr_valid_q <= 1'b0;
      hi_q <= 8'h00;
    end else begin
      if (lnk.rx_done & ((state_q == ST_AHI) | (state_q == ST_WHI))) begin
        hi_q <= lnk.rx_byte;
      end
      if (lnk.rx_done & (state_q == ST_ALO)) begin
        cur_addr_q <= wr_data; // RULE10
      end else if (wr_word | lo_done) begin
        cur_addr_q <= next_addr; // RULE8
      end
      if (err_partial | err_early) begin
        addr_valid_q <= 1'b0; // RULE3 RULE4
      end else if (lnk.rx_done & (state_q == ST_ALO)) begin
        addr_valid_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tx_mode_q <= 1'b0;
      tx_byte_q <= `RFE_IDLE_BYTE;
      lo_q <= 8'h00;
    end else begin
      if (lnk.start | lnk.stop) begin
        tx_mode_q <= 1'b0;
      end else if (rd_ok | err_partial) begin
        tx_mode_q <= 1'b1;
      end
      if (err_partial) begin
        tx_byte_q <= `RFE_IDLE_BYTE; // RULE2
      end else if (rd_ok | lo_done) begin
        tx_byte_q <= rd_word[15:8]; // RULE10
        lo_q <= rd_word[7:0];
      end else if (hi_done) begin
        tx_byte_q <= lo_q;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Hardware set beats a same-cycle software clear
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cmd_err_q <= 1'b0;
      link_fault_q <= 1'b0;
      fault_loc_q <= `RFE_RST_WORD;
    end else begin
      if (err_any) begin
        cmd_err_q <= 1'b1; // RULE5
        link_fault_q <= 1'b1; // RULE6 RULE11
        fault_loc_q <= `RFE_FAULT_LOC_ON_ERR; // RULE7 RULE11
      end else begin
        if (clr_err) begin
          cmd_err_q <= 1'b0;
        end
        if (clr_fault) begin
          link_fault_q <= 1'b0;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  sequence s_read_err;
    err_partial ##1 !addr_valid_q;
  endsequence

  sequence s_word_end;
    lo_done && !lnk.m_nack;
  endsequence

  a_invalid_nack: assert property (err_invalid |=> !ack_q && state_q == ST_IDLE) // RULE1
    else $error("Read at invalid address was acknowledged");
  a_partial_ones: assert property (err_partial |=> tx_byte_q == `RFE_IDLE_BYTE && tx_mode_q) // RULE2
    else $error("Partial address read did not send idle byte");
  a_partial_invalid: assert property (err_partial |-> s_read_err) // RULE3
    else $error("Partial address did not invalidate pointer");
  a_early_invalid: assert property (err_early |=> !addr_valid_q && state_q != ST_RD) // RULE4
    else $error("Early end did not invalidate pointer");
  a_flag_set: assert property (err_any |=> cmd_err_q && cmd_error) // RULE5
    else $error("Command error flag not set");
  a_fault_set: assert property (err_any |=> link_fault_q && cause_word[10]) // RULE6
    else $error("Link protocol fault not set");
  a_loc_zero: assert property (err_any |=> fault_loc_q == 16'h0000) // RULE7 RULE11
    else $error("Fault location not zero after error");
  a_word_advance: assert property (s_word_end |=> cur_addr_q == $past(cur_addr_q) + 16'h0001
                                   && !lo_sel_q && state_q == ST_RD) // RULE8
    else $error("Address did not advance after full word");
  a_foreign_addr: assert property (in_ctrl && !ctrl_match |=> !ack_q ##1 state_q != ST_RD) // RULE9
    else $error("Foreign slave address acknowledged");
  a_addr_order: assert property (lnk.rx_done && state_q == ST_ALO |=>
                                 cur_addr_q == {$past(hi_q), $past(lnk.rx_byte)} && addr_valid_q) // RULE10
    else $error("Word address not assembled upper byte first");
endmodule : rfe_top
`default_nettype wire
